/* hdl/icr_params.svh */
`ifndef ICR_PARAMS_SVH
`define ICR_PARAMS_SVH

// register offsets within the eight-byte window (address bits 2..0)
`define ICR_OFF_IN0      3'h0
`define ICR_OFF_IN1      3'h1
`define ICR_OFF_IN2      3'h2
`define ICR_OFF_IN3      3'h3
`define ICR_OFF_RELAY    3'h4
`define ICR_OFF_GRP_EN   3'h5
`define ICR_OFF_PEND     3'h6
`define ICR_OFF_STATUS   3'h7

// status byte field positions
`define ICR_STAT_ANY     0
`define ICR_STAT_BUSY    1

// reset values and the clear-all mask
`define ICR_RELAY_RST    4'h0
`define ICR_GRP_EN_RST   8'h00
`define ICR_PEND_RST     8'h00
`define ICR_CLR_ALL      8'hff

// interrupt pulse timing
`define ICR_CLK_PERIOD_NS 10
`define ICR_IRQ_LOW_NS    750
`define ICR_IRQ_HIGH_NS   250
`define ICR_IRQ_LOW_CYC   ((`ICR_IRQ_LOW_NS + `ICR_CLK_PERIOD_NS - 1) / `ICR_CLK_PERIOD_NS)
`define ICR_IRQ_HIGH_CYC  ((`ICR_IRQ_HIGH_NS + `ICR_CLK_PERIOD_NS - 1) / `ICR_CLK_PERIOD_NS)

`endif

/* hdl/icr_pkg.sv */
package icr_pkg;

  // interrupt pulse phases, one-hot
  typedef enum logic [2:0] {
    ICR_IDLE = 3'b001,
    ICR_LOW  = 3'b010,
    ICR_HIGH = 3'b100
  } icr_pulse_state_t;

endpackage : icr_pkg

/* hdl/icr_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module icr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // first stage is read only by the second stage
  always_comb begin
    meta_next = d_i;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= meta_next;
      q_o      <= q_next;
    end
  end

endmodule : icr_sync

`default_nettype wire

/* hdl/icr_pulse.sv */
`timescale 1ns/100ps
`default_nettype none

module icr_pulse
  import icr_pkg::*;
#(
  parameter int LOW_CYC  = 75,
  parameter int HIGH_CYC = 25
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request and state
  input  wire logic start_i,
  output var  logic busy_o,
  // line level and drive enable
  output var  logic line_o,
  output var  logic oe_o
);

  icr_pulse_state_t state_reg;
  icr_pulse_state_t state_next;
  logic [7:0]       cnt_reg;
  logic [7:0]       cnt_next;
  logic             line_next;
  logic             oe_next;

  // low phase then high phase, then release; start is ignored while busy
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 8'h01;
    case (state_reg)
      ICR_IDLE: begin
        cnt_next = 8'h00;
        if (start_i) begin
          state_next = ICR_LOW;
        end
      end
      ICR_LOW: begin
        if (cnt_reg == 8'(LOW_CYC - 1)) begin // R10
          state_next = ICR_HIGH;
          cnt_next   = 8'h00;
        end
      end
      ICR_HIGH: begin
        if (cnt_reg == 8'(HIGH_CYC - 1)) begin // R10
          state_next = ICR_IDLE;
          cnt_next   = 8'h00;
        end
      end
      default: begin
        state_next = ICR_IDLE;
        cnt_next   = 8'h00;
      end
    endcase
    line_next = (state_next == ICR_HIGH);
    oe_next   = (state_next != ICR_IDLE); // R9
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ICR_IDLE;
      cnt_reg   <= 8'h00;
      line_o    <= 1'b0;
      oe_o      <= 1'b0;
      busy_o    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      line_o    <= line_next;
      oe_o      <= oe_next;
      busy_o    <= oe_next;
    end
  end

endmodule : icr_pulse

`default_nettype wire

/* hdl/icr_top.sv */
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "icr_params.svh"

// Operation
// [R1] decode exactly eight consecutive byte addresses starting at the base
// [R2] every access is one byte wide; no wider transfer exists
// [R3] thirty-two readable input bits and four relay output bits
// [R4] an energised input reads back as one
// [R5] an enabled input toggling either way raises an interrupt
// [R6] inputs form eight groups of four, each with its own enable
// [R7] host clears a serviced event with a write; the event drops then
// [R8] pending events can be read back by the host
// [R9] interrupt line floats normally; driven for 1 us per event
// [R10] driven interval: 750 ns low, then 250 ns high, then released
// [R11] interrupt routed to one selectable level: 3-7, 9-12, 14, 15
// [R12] relays come up de-energised before any write
// [R13] relay values latched by a write and held until the next
// [R14] address bits 9..3 match the base; bits 2..0 pick the register
// [R15] host places the base between 100 and 3ff hex, without overlap
// [R16] inputs synchronised; event when the sample differs from the previous one
// [R17] a pending event stays latched until the clearing write
module icr_top
  import icr_pkg::*;
#(
  parameter int N_IN     = 32,
  parameter int GRP_W    = 4,
  parameter int N_RELAY  = 4,
  parameter int LOW_CYC  = `ICR_IRQ_LOW_CYC,
  parameter int HIGH_CYC = `ICR_IRQ_HIGH_CYC
) (
  // clock and reset
  input  wire logic         CLK_I,
  input  wire logic         SYS_RST_I,
  // host register port
  input  wire logic [9:0]   BUS_ADDR_I,
  input  wire logic [7:0]   BUS_WDATA_I,
  input  wire logic         BUS_WR_I,
  input  wire logic         BUS_RD_I,
  output var  logic [7:0]   BUS_RDATA_O,
  output var  logic         BUS_RVALID_O,
  // board straps: base address bits 9..3 and interrupt level
  input  wire logic [6:0]   BASE_SEL_I,
  input  wire logic [3:0]   IRQ_SEL_I,
  // isolated inputs and relay drive
  input  wire logic [N_IN-1:0]    IN_I,
  output var  logic [N_RELAY-1:0] RELAY_O,
  // shared interrupt request lines, level and drive enable
  output var  logic [15:0]  IRQ_O,
  output var  logic [15:0]  IRQ_OE_O
);

  localparam int N_GRP = N_IN / GRP_W;

  // only these host request levels may be driven
  function automatic logic irq_level_ok(input logic [3:0] sel);
    case (sel)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h9, 4'ha, 4'hb, 4'hc,
      4'he, 4'hf: irq_level_ok = 1'b1;
      default:    irq_level_ok = 1'b0;
    endcase
  endfunction : irq_level_ok

  logic [N_IN-1:0]    in_sync;
  logic [6:0]         base_sync;
  logic [3:0]         irq_sel_sync;
  logic [N_IN-1:0]    prev_reg;
  logic [N_IN-1:0]    prev_next;
  logic [2:0]         arm_reg;
  logic [2:0]         arm_next;
  logic [N_GRP-1:0]   grp_chg;
  logic [N_GRP-1:0]   grp_set;
  logic [N_GRP-1:0]   en_reg;
  logic [N_GRP-1:0]   en_next;
  logic [N_GRP-1:0]   pend_reg;
  logic [N_GRP-1:0]   pend_next;
  logic [N_GRP-1:0]   clr_mask;
  logic [N_RELAY-1:0] relay_next;
  logic               req_reg;
  logic               req_next;
  logic               pulse_start;
  logic               pulse_busy;
  logic               pulse_line;
  logic               pulse_oe;
  logic               hit;
  logic               wr_hit;
  logic               rd_hit;
  logic [2:0]         off;
  logic [7:0]         rd_mux;
  logic [7:0]         rdata_next;
  logic [15:0]        irq_next;
  logic [15:0]        irq_oe_next;

  // the isolated inputs and both straps cross two flip-flops before use; the bus pins do not
  icr_sync #(.W(N_IN)) u_sync_in (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (IN_I),
    .q_o   (in_sync)
  ); // R16

  icr_sync #(.W(7)) u_sync_base (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (BASE_SEL_I),
    .q_o   (base_sync)
  );

  icr_sync #(.W(4)) u_sync_irq (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (IRQ_SEL_I),
    .q_o   (irq_sel_sync)
  );

  // address decode: upper bits against the strap, low bits pick the byte
  assign off    = BUS_ADDR_I[2:0]; // R14
  assign hit    = (BUS_ADDR_I[9:3] == base_sync); // R1 R14
  assign wr_hit = BUS_WR_I & hit;
  assign rd_hit = BUS_RD_I & hit;

  // per-group change of the synchronised sample against the last one
  generate
    for (genvar g = 0; g < N_GRP; g++) begin : g_grp
      assign grp_chg[g] = |(in_sync[g*GRP_W +: GRP_W] ^ prev_reg[g*GRP_W +: GRP_W]); // R16 R5
    end
  endgenerate

  // arming delay hides the step from reset value to real level
  assign grp_set = grp_chg & en_reg & {N_GRP{arm_reg[2]}}; // R6 R5

  // clear masks: pending byte is write-one-to-clear, status write clears all
  always_comb begin
    clr_mask = '0;
    if (wr_hit && off == `ICR_OFF_PEND) begin
      clr_mask = BUS_WDATA_I[N_GRP-1:0]; // R7
    end else if (wr_hit && off == `ICR_OFF_STATUS) begin
      clr_mask = `ICR_CLR_ALL; // R7
    end
  end

  // next values of the control and event state; set wins over clear
  always_comb begin
    prev_next  = in_sync;
    arm_next   = {arm_reg[1:0], 1'b1};
    en_next    = en_reg;
    relay_next = RELAY_O;
    if (wr_hit && off == `ICR_OFF_GRP_EN) begin
      en_next = BUS_WDATA_I[N_GRP-1:0]; // R6
    end
    if (wr_hit && off == `ICR_OFF_RELAY) begin
      relay_next = BUS_WDATA_I[N_RELAY-1:0]; // R13 R2
    end
    pend_next = (pend_reg & ~clr_mask) | grp_set; // R17 R7
    req_next  = (req_reg & ~pulse_start) | (|grp_set); // R5
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prev_reg <= '0;
      arm_reg  <= 3'h0;
      en_reg   <= `ICR_GRP_EN_RST;
      RELAY_O  <= `ICR_RELAY_RST; // R12
      pend_reg <= `ICR_PEND_RST;
      req_reg  <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      arm_reg  <= arm_next;
      en_reg   <= en_next;
      RELAY_O  <= relay_next; // R13
      pend_reg <= pend_next;
      req_reg  <= req_next;
    end
  end

  // a request that lands mid-pulse waits, so a shared line never sees a merged pulse
  assign pulse_start = req_reg & ~pulse_busy;

  icr_pulse #(
    .LOW_CYC  (LOW_CYC),
    .HIGH_CYC (HIGH_CYC)
  ) u_pulse (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .start_i (pulse_start),
    .busy_o  (pulse_busy),
    .line_o  (pulse_line),
    .oe_o    (pulse_oe)
  ); // R9 R10

  // read mux; every byte of the window answers, upper bits read zero
  always_comb begin
    rd_mux = 8'h00;
    case (off)
      `ICR_OFF_IN0:    rd_mux = in_sync[7:0]; // R3 R4
      `ICR_OFF_IN1:    rd_mux = in_sync[15:8];
      `ICR_OFF_IN2:    rd_mux = in_sync[23:16];
      `ICR_OFF_IN3:    rd_mux = in_sync[31:24];
      `ICR_OFF_RELAY:  rd_mux[N_RELAY-1:0] = RELAY_O;
      `ICR_OFF_GRP_EN: rd_mux[N_GRP-1:0] = en_reg;
      `ICR_OFF_PEND:   rd_mux[N_GRP-1:0] = pend_reg; // R8
      `ICR_OFF_STATUS: begin
        rd_mux[`ICR_STAT_ANY]  = |pend_reg; // R8
        rd_mux[`ICR_STAT_BUSY] = pulse_busy | req_reg;
      end
      default:         rd_mux = 8'h00;
    endcase
    rdata_next = rd_hit ? rd_mux : 8'h00; // R1 R2
  end

  // route the pulse to the one strapped level; bad straps leave all lines floating
  always_comb begin
    irq_next    = {16{pulse_line}};
    irq_oe_next = 16'h0000;
    if (irq_level_ok(irq_sel_sync)) begin
      irq_oe_next[irq_sel_sync] = pulse_oe; // R11 R9
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      BUS_RDATA_O  <= 8'h00;
      BUS_RVALID_O <= 1'b0;
      IRQ_O        <= 16'h0000;
      IRQ_OE_O     <= 16'h0000;
    end else begin
      BUS_RDATA_O  <= rdata_next;
      BUS_RVALID_O <= rd_hit;
      IRQ_O        <= irq_next;
      IRQ_OE_O     <= irq_oe_next;
    end
  end

  // helper run-length counters for the driven phases, read only by assertions
  localparam int LOW_CHK  = LOW_CYC;
  localparam int HIGH_CHK = HIGH_CYC;
  logic       irq_low_w;
  logic       irq_high_w;
  logic [7:0] low_run_reg;
  logic [7:0] high_run_reg;

  assign irq_low_w  = |(IRQ_OE_O & ~IRQ_O);
  assign irq_high_w = |(IRQ_OE_O & IRQ_O);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      low_run_reg  <= 8'h00;
      high_run_reg <= 8'h00;
    end else begin
      low_run_reg  <= irq_low_w ? low_run_reg + 8'h01 : 8'h00;
      high_run_reg <= irq_high_w ? high_run_reg + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_unmapped_quiet: assert property (BUS_RD_I && !hit |=> BUS_RDATA_O == 8'h00) // R1
    else $error("read outside the window returned data");
  a_input_read: assert property (rd_hit && off == `ICR_OFF_IN1 |=> BUS_RDATA_O == $past(in_sync[15:8])) // R4
    else $error("input byte read mismatch");
  a_relay_load: assert property (wr_hit && off == `ICR_OFF_RELAY |=> RELAY_O == $past(BUS_WDATA_I[3:0])) // R13
    else $error("relay write not latched");
  a_relay_hold: assert property (!(wr_hit && off == `ICR_OFF_RELAY) |=> $stable(RELAY_O)) // R13
    else $error("relay changed without a write");
  a_relay_reset: assert property ($past(SYS_RST_I) |-> RELAY_O == 4'h0) // R12
    else $error("relays not de-energised after reset");
  a_toggle_sets: assert property (grp_set != 8'h00 |=> (pend_reg & $past(grp_set)) == $past(grp_set)) // R5
    else $error("enabled toggle not latched");
  a_group_gate: assert property (((pend_reg & ~$past(pend_reg)) & ~$past(en_reg)) == 8'h00) // R6
    else $error("disabled group latched an event");
  a_pend_clear: assert property (wr_hit && off == `ICR_OFF_PEND
                                 |=> (pend_reg & $past(BUS_WDATA_I) & ~$past(grp_set)) == 8'h00) // R7
    else $error("clearing write left event pending");
  a_pend_sticky: assert property (clr_mask == 8'h00 |=> (pend_reg & $past(pend_reg)) == $past(pend_reg)) // R17
    else $error("pending event lost without a clear");
  a_pend_read: assert property (rd_hit && off == `ICR_OFF_PEND |=> BUS_RDATA_O == $past(pend_reg)) // R8
    else $error("pending byte read mismatch");
  a_low_width: assert property ($fell(irq_low_w) |-> low_run_reg == LOW_CHK && irq_high_w) // R10
    else $error("low phase width wrong");
  a_high_width: assert property ($fell(irq_high_w) |-> high_run_reg == HIGH_CHK && IRQ_OE_O == 16'h0000) // R9
    else $error("high phase width wrong or line not released");
  a_one_level: assert property ($onehot0(IRQ_OE_O) && (IRQ_OE_O == 16'h0000 || irq_level_ok(irq_sel_sync))) // R11
    else $error("interrupt driven on a bad or extra level");
  a_pulse_start: assert property (grp_set != 8'h00 && !req_reg && !pulse_busy && irq_level_ok(irq_sel_sync)
                                  |-> ##[2:4] irq_low_w) // R5
    else $error("event did not start an interrupt pulse");
  a_status_clear: assert property (wr_hit && off == `ICR_OFF_STATUS
                                   |=> (pend_reg & ~$past(grp_set)) == 8'h00) // R7
    else $error("status write left an event pending");
  a_status_any: assert property (rd_hit && off == `ICR_OFF_STATUS
                                 |=> BUS_RDATA_O[`ICR_STAT_ANY] == $past(|pend_reg)) // R8
    else $error("status any-pending bit mismatch");
  a_read_valid: assert property (BUS_RVALID_O == $past(rd_hit)) // R1
    else $error("read valid does not follow a hit read");

  c_event_pulse: cover property (grp_set != 8'h00 ##[1:4] irq_low_w);
  c_full_pulse: cover property ($fell(irq_high_w));
  c_pend_clear: cover property (pend_reg != 8'h00 ##1 wr_hit && off == `ICR_OFF_PEND);
  c_relay_write: cover property (wr_hit && off == `ICR_OFF_RELAY && BUS_WDATA_I[3:0] != 4'h0);
  c_queued_pulse: cover property (req_reg && pulse_busy);

endmodule : icr_top

`default_nettype wire

/* sim/icr_host_line.sv */
`timescale 1ns/100ps
`default_nettype none

module icr_host_line (
  // level and drive enable from the device, one per request line
  input  wire logic [15:0] irq_i,
  input  wire logic [15:0] irq_oe_i,
  // level seen by the host on each shared line
  output var  logic [15:0] line_o
);
  // host side pull-up: a released line reads high, never the last driven value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      line_o[i] = irq_oe_i[i] ? irq_i[i] : 1'b1;
    end
  end
endmodule : icr_host_line

`default_nettype wire

/* sim/tb_icr_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_icr_top;
  localparam logic [6:0] BASE    = 7'h60;
  localparam logic [6:0] ELSE    = 7'h61;
  localparam logic [3:0] LVL     = 4'h5;
  localparam logic [3:0] BAD_LVL = 4'h8;

  // stimulus and observed signals
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic [9:0]  addr   = 10'h000;
  logic [7:0]  wdata  = 8'h00;
  logic        wr_s   = 1'b0;
  logic        rd_s   = 1'b0;
  logic [31:0] in_lvl = 32'h0000_0000;
  logic [3:0]  lvl_s  = LVL;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [3:0]  relay;
  logic [15:0] irq;
  logic [15:0] irq_oe;
  logic [15:0] line;
  int          mismatches = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  icr_top dut (
    .CLK_I(clk), .SYS_RST_I(rst), .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata),
    .BUS_WR_I(wr_s), .BUS_RD_I(rd_s), .BUS_RDATA_O(rdata), .BUS_RVALID_O(rvalid),
    .BASE_SEL_I(BASE), .IRQ_SEL_I(lvl_s), .IN_I(in_lvl), .RELAY_O(relay),
    .IRQ_O(irq), .IRQ_OE_O(irq_oe)
  );

  icr_host_line host (.irq_i(irq), .irq_oe_i(irq_oe), .line_o(line));

  // verdict, also reached when a bounded wait runs out
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe; the trailing edge gap keeps strobes from merging
  task wr(input logic [2:0] off, input logic [7:0] d, input logic [6:0] b);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= {b, off};
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so look there
  task rd(input logic [2:0] off, input logic [7:0] exp, input logic v, input logic [6:0] b);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= {b, off};
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rvalid, v, "read valid");
    chk(rdata, exp, "read data");
  endtask : rd

  task wait_oe(input logic lvl);
    int n;
    n = 0;
    #1; // never sample in the time step of the launching edge
    while (irq_oe[LVL] !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        mismatches++;
        $display("BAD %0t interrupt enable wait ran out", $time);
        summarize();
      end
    end
  endtask : wait_oe

  task t_reset;
    #1;
    chk(relay, 4'h0, "relay at reset");
    chk(irq_oe, 16'h0000, "lines released");
    rd(3'h4, 8'h00, 1'b1, BASE);
    rd(3'h6, 8'h00, 1'b1, BASE);
    $display("test reset done");
  endtask : t_reset

  task t_relay;
    wr(3'h4, 8'h0a, BASE);
    @(posedge clk);
    #1;
    chk(relay, 4'ha, "relay drive");
    wr(3'h0, 8'hff, BASE);
    wr(3'h4, 8'h05, ELSE);
    rd(3'h4, 8'h0a, 1'b1, BASE);
    chk(relay, 4'ha, "relay held");
    rd(3'h4, 8'h00, 1'b0, ELSE);
    rd(3'h4, 8'h00, 1'b0, {BASE[6:1], 1'b0} ^ 7'h40);
    $display("test relay done");
  endtask : t_relay

  task t_inputs;
    logic [31:0] pat;
    pat = 32'h8421_c35a;
    @(posedge clk);
    in_lvl <= pat;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(i[2:0], pat[8*i +: 8], 1'b1, BASE);
    end
    $display("test inputs done");
  endtask : t_inputs

  // toggle down then back inside the pulse: one pulse, one queued, event kept
  task t_event;
    int lo;
    int hi;
    logic [15:0] seen;
    lo = 0;
    hi = 0;
    seen = 16'h0000;
    wr(3'h5, 8'h04, BASE);
    rd(3'h5, 8'h04, 1'b1, BASE);
    @(posedge clk);
    in_lvl <= in_lvl ^ 32'h0000_0200;
    repeat (5) @(posedge clk);
    in_lvl <= in_lvl ^ 32'h0000_0200;
    wait_oe(1'b1);
    chk(irq_oe, 16'h0020, "only selected line");
    while (irq_oe[LVL] === 1'b1 && lo + hi < 200) begin
      if (line[LVL] === 1'b0) lo++;
      else hi++;
      @(posedge clk);
      #1;
    end
    if (lo + hi >= 200) begin
      mismatches++;
      $display("BAD %0t pulse length wait ran out", $time);
      summarize();
    end
    chk(lo, 75, "low cycles");
    chk(hi, 25, "high cycles");
    chk(line[LVL], 1'b1, "line released");
    wait_oe(1'b1);
    wait_oe(1'b0);
    rd(3'h6, 8'h04, 1'b1, BASE);
    wr(3'h6, 8'h04, BASE);
    rd(3'h6, 8'h00, 1'b1, BASE);
    @(posedge clk);
    in_lvl <= in_lvl ^ 32'h0000_0001;
    repeat (10) @(posedge clk);
    rd(3'h6, 8'h00, 1'b1, BASE);
    chk(irq_oe, 16'h0000, "no pulse");
    // status byte during a pulse, then the clear-all write
    @(posedge clk);
    in_lvl <= in_lvl ^ 32'h0000_0800;
    wait_oe(1'b1);
    rd(3'h7, 8'h03, 1'b1, BASE);
    wr(3'h7, 8'h00, BASE);
    rd(3'h6, 8'h00, 1'b1, BASE);
    wait_oe(1'b0);
    rd(3'h7, 8'h00, 1'b1, BASE);
    // an unusable level strap: the pulse runs inside, no line is ever driven
    @(posedge clk);
    lvl_s <= BAD_LVL;
    repeat (3) @(posedge clk);
    in_lvl <= in_lvl ^ 32'h0000_0400;
    for (int k = 0; k < 110; k++) begin
      @(posedge clk);
      #1;
      seen = seen | irq_oe;
      if (k == 8) rd(3'h7, 8'h03, 1'b1, BASE);
    end
    chk(seen, 16'h0000, "bad level drove a line");
    rd(3'h7, 8'h01, 1'b1, BASE);
    wr(3'h7, 8'h00, BASE);
    @(posedge clk);
    lvl_s <= LVL;
    $display("test event done");
  endtask : t_event

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_relay();
    t_inputs();
    t_event();
    summarize();
  end
endmodule : tb_icr_top

`default_nettype wire
